// ### lsim_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsim_cfg.svh"
module lsim_master #(
	parameter int QTR_CYC = `LSIM_QTR_CYC
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Request
	input  wire logic       reqValid,
	input  wire logic [6:0] reqSlaveAddr,
	input  wire logic [7:0] reqWordPointer,
	input  wire logic       reqDir,
	input  wire logic [7:0] reqCount,
	output var  logic       reqReady,
	// Write data: wrData is taken when wrTaken pulses
	input  wire logic [7:0] wrData,
	output var  logic       wrTaken,
	// Read data
	output var  logic [7:0] rdData,
	output var  logic       rdValid,
	// Completion
	output var  logic       done,
	output var  logic       error,
	// Bus pins, enable high pulls low
	input  wire logic       sclIn,
	output var  logic       sclOe,
	input  wire logic       sdaIn,
	output var  logic       sdaOe
);
	typedef struct packed {
		lsim_pkg::lsim_state_e state;
		lsim_pkg::lsim_phase_e phase;
		logic [1:0]            qtr;
		logic [2:0]            bitCnt;
		logic [7:0]            shift;
		logic [6:0]            addr;
		logic [7:0]            wordPtr;
		logic                  dir;
		logic [7:0]            remain;
		logic [7:0]            idleCnt;
		logic                  sclOe;
		logic                  sdaOe;
		logic                  reqReady;
		logic                  wrTaken;
		logic [7:0]            rdData;
		logic                  rdValid;
		logic                  done;
		logic                  error;
	} lsim_master_s;
	lsim_master_s st_reg;
	lsim_master_s st_next;
	logic tick;
	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	lsim_tick #(.QTR_CYC(QTR_CYC)) u_tick (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick)
	);
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// A bit is four quarters: qtr0 SCL low set SDA, qtr1-2 SCL high, qtr3 low.
	always_comb begin
		st_next = st_reg;
		st_next.wrTaken = 1'b0;
		st_next.rdValid = 1'b0;
		st_next.done = 1'b0;
		st_next.reqReady = 1'b0;
		case (st_reg.state)
			lsim_pkg::ST_IDLE: begin
				st_next.sclOe = 1'b0;
				st_next.sdaOe = 1'b0;
				// Both lines must stay high for a while; another master may own the bus
				if (tick) begin
					if (sclIn && sdaIn) begin
						if (st_reg.idleCnt != `LSIM_IDLE_QTRS) begin
							st_next.idleCnt = st_reg.idleCnt + 8'h01;
						end
					end else begin
						st_next.idleCnt = 8'h00;
					end
				end
				st_next.reqReady = (st_reg.idleCnt == `LSIM_IDLE_QTRS) && !st_reg.reqReady;
				// Ready is a cycle old; recheck the count so a bus that just turned busy is not grabbed
				if (reqValid && st_reg.reqReady && (st_reg.idleCnt == `LSIM_IDLE_QTRS)) begin
					st_next.reqReady = 1'b0;
					st_next.addr = reqSlaveAddr;
					st_next.wordPtr = reqWordPointer;
					st_next.dir = reqDir;
					st_next.remain = (reqCount == 8'h00) ? 8'h01 : reqCount;
					st_next.error = 1'b0;
					st_next.phase = lsim_pkg::PH_ADDR_W;
					st_next.shift = {reqSlaveAddr, `LSIM_DIR_WRITE};
					st_next.qtr = 2'h0;
					st_next.state = lsim_pkg::ST_START;
				end
			end
			lsim_pkg::ST_START, lsim_pkg::ST_RSTRT: begin
				if (tick) begin
					st_next.qtr = st_reg.qtr + 2'h1;
					case (st_reg.qtr)
						2'h0: begin
							st_next.sdaOe = 1'b0;
						end
						2'h1: begin
							st_next.sclOe = 1'b0;
						end
						2'h2: begin
							st_next.sdaOe = 1'b1;
						end
						default: begin
							st_next.sclOe = 1'b1;
							st_next.bitCnt = 3'h7;
							st_next.state = lsim_pkg::ST_SEND;
						end
					endcase
				end
			end
			lsim_pkg::ST_SEND, lsim_pkg::ST_RECV: begin
				if (tick) begin
					st_next.qtr = st_reg.qtr + 2'h1;
					case (st_reg.qtr)
						2'h0: begin
							st_next.sdaOe = (st_reg.state == lsim_pkg::ST_SEND) ? !st_reg.shift[7] : 1'b0;
						end
						2'h1: begin
							st_next.sclOe = 1'b0;
						end
						2'h2: begin
							if (st_reg.state == lsim_pkg::ST_RECV) begin
								st_next.shift = {st_reg.shift[6:0], sdaIn};
							end
						end
						default: begin
							st_next.sclOe = 1'b1;
							if (st_reg.state == lsim_pkg::ST_SEND) begin
								st_next.shift = {st_reg.shift[6:0], 1'b0};
							end
							st_next.bitCnt = st_reg.bitCnt - 3'h1;
							if (st_reg.bitCnt == 3'h0) begin
								st_next.state = (st_reg.state == lsim_pkg::ST_SEND) ? lsim_pkg::ST_SACK : lsim_pkg::ST_MACK;
							end
						end
					endcase
				end
			end
			lsim_pkg::ST_SACK: begin
				if (tick) begin
					st_next.qtr = st_reg.qtr + 2'h1;
					case (st_reg.qtr)
						2'h0: begin
							st_next.sdaOe = 1'b0;
						end
						2'h1: begin
							st_next.sclOe = 1'b0;
						end
						2'h2: begin
							if (sdaIn) begin
								st_next.error = 1'b1;
							end
						end
						default: begin
							st_next.sclOe = 1'b1;
							st_next.bitCnt = 3'h7;
							if (st_reg.error) begin
								st_next.state = lsim_pkg::ST_STOP;
							end else begin
								case (st_reg.phase)
									lsim_pkg::PH_ADDR_W: begin
										st_next.phase = lsim_pkg::PH_WORD;
										st_next.shift = st_reg.wordPtr;
										st_next.state = lsim_pkg::ST_SEND;
									end
									lsim_pkg::PH_WORD: begin
										st_next.phase = (st_reg.dir == `LSIM_DIR_READ) ? lsim_pkg::PH_ADDR_R : lsim_pkg::PH_DATA;
										if (st_reg.dir == `LSIM_DIR_READ) begin
											st_next.shift = {st_reg.addr, `LSIM_DIR_READ};
											st_next.state = lsim_pkg::ST_RSTRT;
										end else begin
											st_next.shift = wrData;
											st_next.wrTaken = 1'b1;
											st_next.state = lsim_pkg::ST_SEND;
										end
									end
									lsim_pkg::PH_ADDR_R: begin
										st_next.phase = lsim_pkg::PH_DATA;
										st_next.state = lsim_pkg::ST_RECV;
									end
									default: begin
										st_next.remain = st_reg.remain - 8'h01;
										if (st_reg.remain == 8'h01) begin
											st_next.state = lsim_pkg::ST_STOP;
										end else begin
											st_next.shift = wrData;
											st_next.wrTaken = 1'b1;
											st_next.state = lsim_pkg::ST_SEND;
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			lsim_pkg::ST_MACK: begin
				if (tick) begin
					st_next.qtr = st_reg.qtr + 2'h1;
					case (st_reg.qtr)
						2'h0: begin
							st_next.sdaOe = (st_reg.remain != 8'h01);
							st_next.rdData = st_reg.shift;
							st_next.rdValid = 1'b1;
						end
						2'h1: begin
							st_next.sclOe = 1'b0;
						end
						2'h2: begin
						end
						default: begin
							st_next.sclOe = 1'b1;
							st_next.bitCnt = 3'h7;
							st_next.remain = st_reg.remain - 8'h01;
							st_next.state = (st_reg.remain == 8'h01) ? lsim_pkg::ST_STOP : lsim_pkg::ST_RECV;
						end
					endcase
				end
			end
			lsim_pkg::ST_STOP: begin
				if (tick) begin
					st_next.qtr = st_reg.qtr + 2'h1;
					case (st_reg.qtr)
						2'h0: begin
							st_next.sdaOe = 1'b1;
						end
						2'h1: begin
							st_next.sclOe = 1'b0;
						end
						2'h2: begin
							st_next.sdaOe = 1'b0;
						end
						default: begin
							st_next.state = lsim_pkg::ST_DONE;
						end
					endcase
				end
			end
			lsim_pkg::ST_DONE: begin
				st_next.done = 1'b1;
				st_next.idleCnt = 8'h00;
				st_next.state = lsim_pkg::ST_IDLE;
			end
			default: begin
				st_next.state = lsim_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.state <= lsim_pkg::ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end
	assign reqReady = st_reg.reqReady;
	assign wrTaken  = st_reg.wrTaken;
	assign rdData   = st_reg.rdData;
	assign rdValid  = st_reg.rdValid;
	assign done     = st_reg.done;
	assign error    = st_reg.error;
	assign sclOe    = st_reg.sclOe;
	assign sdaOe    = st_reg.sdaOe;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_start_idle: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_IDLE && st_next.state == lsim_pkg::ST_START)
		|-> st_reg.idleCnt == `LSIM_IDLE_QTRS) else $error("start on busy bus");
	chk_addr_dir: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_START && st_next.state == lsim_pkg::ST_SEND)
		|-> st_reg.shift[0] == `LSIM_DIR_WRITE) else $error("first address not write");
	chk_rstart_place: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_RSTRT) |-> st_reg.phase == lsim_pkg::PH_ADDR_R) else $error("bad restart");
	chk_nack_last: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_MACK && tick && st_reg.qtr == 2'h0 && st_reg.remain == 8'h01)
		|=> !st_reg.sdaOe) else $error("last byte acked");
	chk_ack_more: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_MACK && tick && st_reg.qtr == 2'h0 && st_reg.remain != 8'h01)
		|=> st_reg.sdaOe) else $error("middle byte not acked");
	chk_nack_stop: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_MACK && st_next.state == lsim_pkg::ST_STOP)
		|-> st_reg.remain == 8'h01) else $error("stop not after last");
	chk_err_abort: assert property (@(posedge clk) disable iff (!reset_n)
		(st_reg.state == lsim_pkg::ST_SACK && st_reg.error && tick && st_reg.qtr == 2'h3)
		|=> st_reg.state == lsim_pkg::ST_STOP) else $error("no abort on nack");
	chk_done_after: assert property (@(posedge clk) disable iff (!reset_n)
		st_reg.done |-> $past(st_reg.state) == lsim_pkg::ST_DONE && !st_reg.sdaOe && !st_reg.sclOe)
		else $error("done without stop");
	chk_tick_rate: assert property (@(posedge clk) disable iff (!reset_n)
		tick |=> !tick [*3]) else $error("tick too fast");
	cov_write: cover property (@(posedge clk) st_reg.wrTaken);
	cov_read: cover property (@(posedge clk) st_reg.rdValid);
	cov_error: cover property (@(posedge clk) st_reg.done && st_reg.error);
	cov_rstart: cover property (@(posedge clk) st_reg.state == lsim_pkg::ST_RSTRT);
endmodule : lsim_master
`default_nettype wire

// ### lsim_cfg.svh
`ifndef LSIM_CFG_SVH
`define LSIM_CFG_SVH
`define LSIM_CLK_HZ       40000000
`define LSIM_SCL_HZ       100000
// Quarter of an SCL period in system clocks
`define LSIM_QTR_CYC      (`LSIM_CLK_HZ / (`LSIM_SCL_HZ * 4))
`define LSIM_DIR_WRITE    1'b0
`define LSIM_DIR_READ     1'b1
`define LSIM_IDLE_QTRS    8'h04
`endif

// ### lsim_pkg.sv
package lsim_pkg;
	typedef enum logic [10:0] {
		ST_IDLE  = 11'h001,
		ST_START = 11'h002,
		ST_SEND  = 11'h004,
		ST_SACK  = 11'h008,
		ST_RSTRT = 11'h010,
		ST_RECV  = 11'h020,
		ST_MACK  = 11'h040,
		ST_STOP  = 11'h080,
		ST_DONE  = 11'h100,
		ST_WAIT  = 11'h200,
		ST_SPARE = 11'h400
	} lsim_state_e;
	typedef enum logic [1:0] {
		PH_ADDR_W = 2'h0,
		PH_WORD   = 2'h1,
		PH_ADDR_R = 2'h2,
		PH_DATA   = 2'h3
	} lsim_phase_e;
endpackage : lsim_pkg

// ### lsim_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsim_cfg.svh"
// ----------------------------------------
// Quarter-bit tick divider
// ----------------------------------------
module lsim_tick #(
	parameter int QTR_CYC = `LSIM_QTR_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Tick
	output var  logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} lsim_tick_s;
	lsim_tick_s st_reg;
	lsim_tick_s st_next;
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == 16'(QTR_CYC - 1)) begin
			st_next.cnt = 16'h0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 16'h0001;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tick = st_reg.tick;
endmodule : lsim_tick
`default_nettype wire

// ### lsim_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Sensor slave model
// ----------------------------------------
module lsim_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// Clock
	input  wire logic clk,
	// Wire levels and pull-down
	input  wire logic scl,
	input  wire logic sda,
	output var  logic sdaOe
);
	logic [7:0] mem [256];
	logic [7:0] ptr, sh, tx;
	logic       sclP, sdaP, first, sel, rd, havePtr, mAck, oe;
	int         cnt;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i * 3 + 1);
		{oe, first, sel, rd, havePtr, ptr} = 13'h0000;
		{sclP, sdaP, mAck} = 3'h7;
		cnt = 0;
	end
	// Edges are seen through the system clock; fine at the bus rate
	always @(posedge clk) begin
		if (scl && sclP && sdaP && !sda) begin
			cnt = 0;
			{first, sel, havePtr, mAck, oe} = 5'h12;
		end else if (scl && sclP && !sdaP && sda) begin
			{first, sel, oe} = 3'h0;
		end else if (scl && !sclP) begin
			if (cnt < 8) sh = {sh[6:0], sda};
			else mAck = !sda;
			cnt++;
		end else if (!scl && sclP) begin
			oe = 1'h0;
			if (cnt == 8) begin
				if (first) begin
					sel = (sh[7:1] == ADDR);
					rd = sh[0];
					first = 1'h0;
					oe = sel;
				end else if (sel && !rd) begin
					if (havePtr) begin
						mem[ptr] = sh;
						ptr++;
					end else begin
						ptr = sh;
						havePtr = 1'h1;
					end
					oe = 1'h1;
				end
			end else if (cnt == 9) begin
				cnt = 0;
			end
			// A NACK from the master ends our turn as transmitter
			if (sel && rd && mAck && cnt < 8) begin
				if (cnt == 0) begin
					tx = mem[ptr];
					ptr++;
				end
				oe = !tx[7 - cnt];
			end
		end
		sclP = scl;
		sdaP = sda;
		// The pin moves by non-blocking assignment so the master never races it at the edge
		sdaOe <= oe;
	end
endmodule : lsim_slave_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Sensor link master bench
// ----------------------------------------
module tb;
	localparam int         QTR   = 4;
	localparam logic [6:0] SADDR = 7'h2A;
	logic       clk, reset_n, reqValid, reqDir, reqReady, wrTaken, rdValid, done, error;
	logic       sclOe, sdaOe, slvOe, busOther, scl, sda, sclQ, sdaQ, curRead;
	logic [6:0] reqSlaveAddr;
	logic [7:0] reqWordPointer, reqCount, wrData, rdData;
	logic [7:0] mirror [256];
	logic [7:0] expRd [$];
	logic [7:0] wq [$];
	logic       expErr [$];
	int         errorCnt, totalChecks, gap, hits;
	integer     seed;
	// Open-drain wires with pull-ups
	assign scl = !sclOe;
	assign sda = !(sdaOe || slvOe || busOther);
	always #12.5 clk = !clk;
	lsim_master #(.QTR_CYC(QTR)) i_lsim_master (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
		.reqSlaveAddr(reqSlaveAddr), .reqWordPointer(reqWordPointer), .reqDir(reqDir), .reqCount(reqCount),
		.reqReady(reqReady), .wrData(wrData), .wrTaken(wrTaken), .rdData(rdData), .rdValid(rdValid),
		.done(done), .error(error), .sclIn(scl), .sclOe(sclOe), .sdaIn(sda), .sdaOe(sdaOe));
	lsim_slave_model #(.ADDR(SADDR)) i_lsim_slave_model (.clk(clk), .scl(scl), .sda(sda), .sdaOe(slvOe));
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic results();
		if (errorCnt == 0 && totalChecks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	task automatic miss(input string m);
		errorCnt++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : miss
	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) miss($sformatf("byte %h, wanted %h", got, exp));
	endtask : cmpByte
	task automatic cmpFlag(input logic got, input logic exp, input string m);
		totalChecks++;
		if (got !== exp) miss(m);
	endtask : cmpFlag
	// Result watcher
	always @(posedge clk) begin
		gap <= gap + 1;
		if (scl && !sclQ) begin
			cmpFlag(gap >= 4 * QTR - 1, 1'h1, "bus clock too fast");
			gap <= 0;
		end
		if (scl && sclQ && !sdaQ && sda && curRead) cmpFlag(i_lsim_slave_model.mAck, 1'h0, "last byte acked");
		if (rdValid === 1'h1) begin
			if (expRd.size() == 0) miss("spare byte");
			else cmpByte(rdData, expRd.pop_front());
		end
		if (done === 1'h1) begin
			if (expErr.size() == 0) miss("spare done");
			else cmpFlag(error, expErr.pop_front(), "error flag");
		end
		if (wrTaken === 1'h1 && wq.size() > 1) begin
			void'(wq.pop_front());
			wrData <= wq[0];
		end
		sclQ <= scl;
		sdaQ <= sda;
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic d, input logic [7:0] n);
		int  k;
		logic ok;
		ok = (a == SADDR);
		for (int i = 0; i < ((n == 8'h00) ? 1 : int'(n)); i++) begin
			if (!d) wq.push_back(8'($random(seed)));
			if (ok && d) expRd.push_back(mirror[8'(p + i)]);
			if (ok && !d) mirror[8'(p + i)] = wq[i];
		end
		expErr.push_back(!ok);
		curRead = d && ok;
		reqSlaveAddr <= a;
		reqWordPointer <= p;
		reqDir <= d;
		reqCount <= n;
		reqValid <= 1'h1;
		if (!d) wrData <= wq[0];
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (reqReady !== 1'h1 && k < 3000);
		reqValid <= 1'h0;
		while (done !== 1'h1 && k < 9000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 9000) begin
			miss("transfer hung");
			results();
		end
		@(posedge clk);
		wq.delete();
	endtask : xfer
	initial begin
		clk = 1'h0;
		reset_n = 1'h0;
		{reqValid, reqDir, busOther, curRead} = 4'h0;
		reqSlaveAddr = 7'h00;
		{reqWordPointer, reqCount, wrData} = 24'h000000;
		{sclQ, sdaQ} = 2'h3;
		{errorCnt, totalChecks, gap} = 96'h0;
		seed = 32'h40004270;
		for (int i = 0; i < 256; i++) mirror[i] = 8'(i * 3 + 1);
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		// Another master owns the bus: nothing may be offered meanwhile
		busOther <= 1'h1;
		hits = 0;
		repeat (200) begin
			@(posedge clk);
			if (reqReady === 1'h1) hits++;
		end
		cmpFlag(hits == 0, 1'h1, "ready on busy bus");
		busOther <= 1'h0;
		xfer(SADDR, 8'hFE, 1'h0, 8'h03);
		xfer(SADDR, 8'hFE, 1'h1, 8'h03);
		xfer(SADDR, 8'h40, 1'h0, 8'h01);
		xfer(SADDR, 8'h40, 1'h1, 8'h00);
		xfer(7'h15, 8'h10, 1'h0, 8'h02);
		xfer(7'h15, 8'h10, 1'h1, 8'h02);
		repeat (6) xfer(SADDR, 8'($random(seed)), 1'($random(seed)), 8'($random(seed) & 7));
		results();
	end
endmodule : tb
`default_nettype wire
